// >>> inc/touch_adc_pkg.sv
// Shared types and constants for the touch panel converter sequencer.
// Assumes a single 100 MHz system clock and no register bus.
package touch_adc_pkg;

   // ======
   // Clocking
   localparam int unsigned SYS_CLK_HZ      = 100000000;
   localparam int unsigned INT_CLK_HZ      = 8000000;   // Nominal internal state clock
   // System cycles per internal clock tick, rounded down
   localparam int unsigned INT_TICK_CYC    = SYS_CLK_HZ / INT_CLK_HZ;
   localparam int unsigned SAMPLE_INT_CYC  = 3;          // Internal cycles spent sampling

   // ======
   // Reset values
   localparam logic [7:0]  STAB_DELAY_RST  = 8'h00;
   localparam logic [15:0] RESULT_RST      = 16'h0000;

   // ======
   // Modes and encodings
   typedef enum logic [1:0] {
      MODE_TOUCH_AUTO = 2'h0,  // Sequenced, started by touch
      MODE_HOST_START = 2'h1,  // Sequenced, started by host after pen interrupt
      MODE_HOST_CTRL  = 2'h2   // Host does every step
   } conv_mode_t;

   typedef enum logic [1:0] {
      RES_12 = 2'h0,
      RES_8  = 2'h1,
      RES_10 = 2'h2
   } resolution_t;

   typedef enum logic [1:0] {
      DIV_1 = 2'h0,   // 8 MHz
      DIV_2 = 2'h1,   // 4 MHz
      DIV_4 = 2'h2,   // 2 MHz
      DIV_8 = 2'h3    // 1 MHz
   } clk_div_t;

   typedef enum logic [2:0] {
      CH_Y    = 3'h0,
      CH_X    = 3'h1,
      CH_PR1  = 3'h2,
      CH_PR2  = 3'h3,
      CH_BAT  = 3'h4,
      CH_TEMP = 3'h5,
      CH_AUX  = 3'h6
   } channel_t;

   typedef enum logic [1:0] {
      SCAN_XY   = 2'h0,
      SCAN_XYZ  = 2'h1,
      SCAN_X    = 2'h2,
      SCAN_ONE  = 2'h3   // Single selected channel
   } scan_t;

   typedef enum logic [1:0] {
      HCMD_NONE    = 2'h0,
      HCMD_DRIVE   = 2'h1,  // Enable panel drivers only
      HCMD_CONVERT = 2'h2,  // Convert now
      HCMD_SCAN    = 2'h3   // Start a sequenced scan
   } host_cmd_t;

   // Converter control settings
   typedef struct packed {
      conv_mode_t  mode;
      channel_t    channel;
      scan_t       scan;
      logic        average;   // Average two conversions
      resolution_t res;
      clk_div_t    div;
   } adc_ctrl_t;

   // Reference control settings
   typedef struct packed {
      logic intRefOn;     // Internal reference enabled
      logic ref2v5;       // 1: 2.5 V, 0: 1.2 V
      logic refAutoPd;    // Power down while the sequencer is idle
   } ref_ctrl_t;

   // Panel switch states
   typedef struct packed {
      logic ypToVdd;
      logic ynToGnd;
      logic xpToVdd;
      logic xnToGnd;
      logic xpPullup;      // Touch-detect pull-up on x-positive
      logic xpToPenIrq;    // Pen interrupt path from x-positive
   } panel_sw_t;

   // Converter front-end selection
   typedef struct packed {
      logic [2:0] muxSel;
      logic       diffMode;   // Ratiometric differential reference
      logic       useIntRef;
      logic       refPowerOn;
      logic       ref2v5;
   } afe_sel_t;

   localparam int unsigned NUM_RESULTS = 7;

   function automatic logic [3:0] res_bits(input resolution_t r);
      case (r)
         RES_8:   return 4'h8;
         RES_10:  return 4'ha;
         default: return 4'hc;
      endcase
   endfunction : res_bits

endpackage : touch_adc_pkg

// >>> hw/result_mem.sv
// Small register memory for conversion results, registered read port.
// Assumes one writer and one reader on the system clock.
`timescale 1ns/1ns
module result_mem #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 7
) (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // Write port
   input  wire logic                     wrEn,
   input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
   input  wire logic [WIDTH-1:0]         wrData,
   // Read port
   input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
   output logic      [WIDTH-1:0]         rdData
);
   import touch_adc_pkg::*;

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [WIDTH-1:0] rd_ff;
   logic [WIDTH-1:0] nxt_rd;

   // ======
   // Next contents
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         nxt_mem[i] = mem_ff[i];
         if (wrEn && (int'(wrAddr) == i)) nxt_mem[i] = wrData;
      end
      nxt_rd = (int'(rdAddr) < DEPTH) ? mem_ff[rdAddr] : '0;
   end

   // Storage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) mem_ff[i] <= '0;
         rd_ff <= '0;
      end else begin
         mem_ff <= nxt_mem;
         rd_ff  <= nxt_rd;
      end
   end

   assign rdData = rd_ff;
endmodule : result_mem

// >>> hw/sar_engine.sv
// Successive-approximation bit sequencer on a divided conversion clock.
// Assumes the comparator settles within one tick.
`timescale 1ns/1ns
module sar_engine (
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   // Control
   input  wire logic                      start,
   input  wire touch_adc_pkg::resolution_t res,
   input  wire touch_adc_pkg::clk_div_t    div,
   // Analog side
   input  wire logic                      cmpIn,    // Comparator, synchronised
   output logic                           sampling,
   output logic      [11:0]               dacCode,
   // Result
   output logic                           done,
   output logic      [11:0]               code
);
   import touch_adc_pkg::*;

   typedef enum logic [1:0] {
      SAR_IDLE   = 2'b00,
      SAR_SAMPLE = 2'b01,
      SAR_BITS   = 2'b11,
      SAR_DONE   = 2'b10
   } sar_state_t;

   sar_state_t  state_ff, nxt_state;
   logic [7:0]  tick_ff, nxt_tick;     // System cycles in current tick
   logic [3:0]  cnt_ff, nxt_cnt;       // Internal ticks while sampling
   logic [3:0]  bit_ff, nxt_bit;
   logic [11:0] sar_ff, nxt_sar;
   logic [7:0]  tickLen;
   logic        samp_ff;

   // Conversion tick length from the divider, internal clock unchanged
   always_comb begin
      tickLen = 8'(INT_TICK_CYC);
      if (state_ff == SAR_BITS) tickLen = 8'(INT_TICK_CYC << div);   // [R10]
   end

   // ======
   // Sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_tick  = tick_ff;
      nxt_cnt   = cnt_ff;
      nxt_bit   = bit_ff;
      nxt_sar   = sar_ff;
      case (state_ff)
         SAR_IDLE: begin
            if (start) begin
               nxt_state = SAR_SAMPLE;
               nxt_tick  = '0;
               nxt_cnt   = '0;
               nxt_sar   = '0;
            end
         end
         SAR_SAMPLE: begin
            // Fixed internal-clock sampling time
            nxt_tick = tick_ff + 8'h01;
            if (tick_ff == tickLen - 8'h01) begin
               nxt_tick = '0;
               nxt_cnt  = cnt_ff + 4'h1;
               if (cnt_ff == 4'(SAMPLE_INT_CYC - 1)) begin   // [R16]
                  nxt_state = SAR_BITS;
                  nxt_bit   = 4'hb;
                  nxt_sar   = 12'h800;
               end
            end
         end
         SAR_BITS: begin
            nxt_tick = tick_ff + 8'h01;
            if (tick_ff == tickLen - 8'h01) begin
               nxt_tick = '0;
               if (!cmpIn) nxt_sar[bit_ff] = 1'b0;
               // Stop early at lower resolution
               if (bit_ff == 4'hc - res_bits(res)) begin   // [R9]
                  nxt_state = SAR_DONE;
               end else begin
                  nxt_bit          = bit_ff - 4'h1;
                  nxt_sar[nxt_bit] = 1'b1;
               end
            end
         end
         SAR_DONE: nxt_state = SAR_IDLE;
         default:  nxt_state = SAR_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SAR_IDLE;
         tick_ff  <= '0;
         cnt_ff   <= '0;
         bit_ff   <= '0;
         sar_ff   <= '0;
         samp_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         tick_ff  <= nxt_tick;
         cnt_ff   <= nxt_cnt;
         bit_ff   <= nxt_bit;
         sar_ff   <= nxt_sar;
         samp_ff  <= (nxt_state == SAR_SAMPLE);
      end
   end

   // Right-justified straight binary code
   assign sampling = samp_ff;
   assign dacCode  = sar_ff;
   assign done     = (state_ff == SAR_DONE);
   assign code     = sar_ff >> (4'hc - res_bits(res));   // [R15]
endmodule : sar_engine

// >>> hw/touch_panel_adc_sequencer.sv
// Touch panel converter sequencer: panel switches, measurement order,
// stabilisation delay, reference control and result storage.
// Assumes host strobes on clk_sys and asynchronous pin inputs.
`timescale 1ns/1ns

// Notes on behaviour
// R1: Y measure: x-positive to converter, y-positive to supply, y-negative grounded.
// R2: After Y, drive the x axis and convert the X position.
// R3: Pressure scans add two cross-panel conversions after X.
// R4: Programmable stabilisation delay from driver enable to conversion start.
// R5: Driver-only command enables drivers; host later asks for the conversion.
// R6: Three modes: touch started, host started, fully host controlled.
// R7: Control port sets channel, scan, averaging, resolution and rate.
// R8: Each result lands in the register of its measured input.
// R9: Resolution of 8, 10 or 12 bits; fewer bits convert faster.
// R10: Internal 8 MHz ticks drive sequencing; conversion clock is divided.
// R11: Software pairs 8 MHz with 8 bits, 4 MHz with 10, 1-2 MHz with 12.
// R12: Internal reference 1.2 V or 2.5 V, auto power-down or always on.
// R13: Internal reference may be off, using the external reference input.
// R14: Panel measures differential ratiometric; internal reference only single-ended.
// R15: Results are unsigned straight binary.
// R16: Total time adds sampling ticks and stabilisation delay to conversion.
// R17: Pen interrupt follows pulled-up x-positive; disconnected while measuring.
// R18: Result-ready goes low on new data, high after host reads all.
// R19: Host-controlled mode idles between commands, doing only the asked step.
module touch_panel_adc_sequencer (
   // Clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst_n,
   // Configuration
   input  wire touch_adc_pkg::adc_ctrl_t  adcCtrl,
   input  wire touch_adc_pkg::ref_ctrl_t  refCtrl,
   input  wire logic [7:0]                stabDelay,    // Internal clock ticks
   // Host commands
   input  wire logic                      hostCmdValid,
   input  wire touch_adc_pkg::host_cmd_t  hostCmd,
   input  wire logic                      rdStrobe,
   input  wire logic [2:0]                rdAddr,
   output logic      [15:0]               rdData,
   // Panel and analog front end
   input  wire logic                      xpSense,      // x-positive level pin
   input  wire logic                      cmpPin,       // Comparator output pin
   input  wire logic                      ext_reference_input,
   output touch_adc_pkg::panel_sw_t       panelSw,
   output touch_adc_pkg::afe_sel_t        afeSel,
   output logic      [11:0]               dacCode,
   output logic                           sampling,
   // Status
   output logic                           pen_touch_irq_n,
   output logic                           result_ready_flag_n,
   output logic                           busy
);
   import touch_adc_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_DRIVE  = 3'b001,   // Drivers on, stabilisation wait
      ST_CONV   = 3'b011,
      ST_WAIT   = 3'b010,   // Waiting on converter
      ST_STORE  = 3'b110,
      ST_HOLD   = 3'b111    // Drivers held for host conversion
   } seq_state_t;

   // Input synchronisers
   logic [1:0] xpSync_ff, cmpSync_ff, extRefSync_ff;
   logic       penDown, cmpIn;

   seq_state_t  state_ff, nxt_state;
   channel_t    ch_ff, nxt_ch;
   logic [7:0]  dly_ff, nxt_dly;
   logic [3:0]  tick_ff, nxt_tick;
   logic        avgPass_ff, nxt_avgPass;
   logic [12:0] accum_ff, nxt_accum;
   logic [6:0]  newData_ff, nxt_newData;
   logic        sarStart, sarDone, sarSampling;
   logic [11:0] sarCode, sarDac;
   logic        wrEn;
   logic [15:0] wrData;
   logic        pen_touch_irq_ff, nxt_pen_touch_irq;
   logic        ready_ff, nxt_ready;
   panel_sw_t   sw_ff, nxt_sw;
   afe_sel_t    afe_ff, nxt_afe;
   logic        busy_ff, nxt_busy;

   // Next channel of a scan; CH_Y ends it
   function automatic channel_t next_ch(input channel_t c, input scan_t s);
      case (c)
         CH_Y:    return (s == SCAN_X) ? CH_Y : CH_X;
         CH_X:    return (s == SCAN_XYZ) ? CH_PR1 : CH_Y;
         CH_PR1:  return CH_PR2;
         default: return CH_Y;
      endcase
   endfunction : next_ch

   // Panel switches for a channel
   function automatic panel_sw_t drive_for(input channel_t c);
      panel_sw_t p;
      p = '0;
      case (c)
         CH_Y: begin
            p.ypToVdd = 1'b1;                         // [R1]
            p.ynToGnd = 1'b1;
         end
         CH_X: begin
            p.xpToVdd = 1'b1;                         // [R2]
            p.xnToGnd = 1'b1;
         end
         CH_PR1, CH_PR2: begin
            p.ypToVdd = 1'b1;                         // [R3]
            p.xnToGnd = 1'b1;
         end
         default: p = '0;
      endcase
      return p;
   endfunction : drive_for

   // Front-end mux and reference per channel
   function automatic afe_sel_t afe_for(input channel_t c, input ref_ctrl_t r,
                                        input logic active);
      afe_sel_t a;
      logic     panel;
      panel       = (c <= CH_PR2);
      a.muxSel    = c;
      a.diffMode  = panel;                                       // [R14]
      a.useIntRef = !panel && r.intRefOn;                        // [R13]
      a.refPowerOn = r.intRefOn && (!r.refAutoPd || active);     // [R12]
      a.ref2v5    = r.ref2v5;
      return a;
   endfunction : afe_for

   // ======
   // Pin synchronisers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         xpSync_ff     <= 2'h3;
         cmpSync_ff    <= 2'h0;
         extRefSync_ff <= 2'h0;
      end else begin
         xpSync_ff     <= {xpSync_ff[0], xpSense};
         cmpSync_ff    <= {cmpSync_ff[0], cmpPin};
         extRefSync_ff <= {extRefSync_ff[0], ext_reference_input};
      end
   end
   assign penDown = !xpSync_ff[1];
   assign cmpIn   = cmpSync_ff[1];

   // ======
   // Converter and result storage
   sar_engine u_sar (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .start    (sarStart),
      .res      (adcCtrl.res),
      .div      (adcCtrl.div),
      .cmpIn    (cmpIn),
      .sampling (sarSampling),
      .dacCode  (sarDac),
      .done     (sarDone),
      .code     (sarCode)
   );

   result_mem #(.WIDTH(16), .DEPTH(NUM_RESULTS)) u_mem (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wrEn    (wrEn),
      .wrAddr  (ch_ff),                                         // [R8]
      .wrData  (wrData),
      .rdAddr  (rdAddr),
      .rdData  (rdData)
   );

   // ======
   // Measurement sequencer
   always_comb begin
      nxt_state   = state_ff;
      nxt_ch      = ch_ff;
      nxt_dly     = dly_ff;
      nxt_tick    = tick_ff;
      nxt_avgPass = avgPass_ff;
      nxt_accum   = accum_ff;
      sarStart    = 1'b0;
      wrEn        = 1'b0;
      wrData      = RESULT_RST;
      case (state_ff)
         ST_IDLE: begin
            nxt_avgPass = 1'b0;
            nxt_accum   = '0;
            nxt_dly     = stabDelay;
            nxt_tick    = '0;
            nxt_ch      = (adcCtrl.scan == SCAN_ONE) ? adcCtrl.channel :
                          (adcCtrl.scan == SCAN_X) ? CH_X : CH_Y;
            case (adcCtrl.mode)                               // [R6] [R7]
               MODE_TOUCH_AUTO: if (penDown) nxt_state = ST_DRIVE;
               MODE_HOST_START: if (hostCmdValid && hostCmd == HCMD_SCAN)
                                   nxt_state = ST_DRIVE;
               default: begin
                  // Only the step the host asks for
                  if (hostCmdValid && hostCmd == HCMD_DRIVE)     // [R19]
                     nxt_state = ST_HOLD;                       // [R5]
                  else if (hostCmdValid && hostCmd == HCMD_CONVERT)
                     nxt_state = ST_CONV;
               end
            endcase
         end
         ST_DRIVE: begin
            // Panel settling, counted in internal ticks
            nxt_tick = tick_ff + 4'h1;
            if (tick_ff == 4'(INT_TICK_CYC - 1)) begin
               nxt_tick = '0;
               if (dly_ff != 8'h00) nxt_dly = dly_ff - 8'h01;  // [R4]
            end
            if (dly_ff == 8'h00) nxt_state = ST_CONV;          // [R16]
         end
         ST_HOLD: begin
            if (hostCmdValid && hostCmd == HCMD_CONVERT) nxt_state = ST_CONV;
         end
         ST_CONV: begin
            sarStart  = 1'b1;
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (sarDone) begin
               nxt_accum = accum_ff + {1'b0, sarCode};
               if (adcCtrl.average && !avgPass_ff) begin
                  nxt_avgPass = 1'b1;
                  nxt_state   = ST_CONV;
               end else begin
                  nxt_state = ST_STORE;
               end
            end
         end
         ST_STORE: begin
            wrEn   = 1'b1;
            wrData = {4'h0, adcCtrl.average ? accum_ff[12:1] : accum_ff[11:0]};
            nxt_avgPass = 1'b0;
            nxt_accum   = '0;
            nxt_dly     = stabDelay;
            nxt_tick    = '0;
            nxt_ch      = next_ch(ch_ff, adcCtrl.scan);
            if (adcCtrl.mode == MODE_HOST_CTRL || adcCtrl.scan == SCAN_ONE ||
                nxt_ch == CH_Y)
               nxt_state = ST_IDLE;
            else
               nxt_state = ST_DRIVE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // ======
   // Output and flag next values
   always_comb begin
      logic measuring;
      measuring   = (state_ff != ST_IDLE);
      nxt_busy    = measuring;
      nxt_sw      = measuring ? drive_for(ch_ff) : '0;
      // Touch monitoring: pull-up on x-positive, y-negative grounded
      nxt_sw.xpPullup   = !measuring;                          // [R17]
      nxt_sw.xpToPenIrq = !measuring;
      if (!measuring) nxt_sw.ynToGnd = 1'b1;
      nxt_pen_touch_irq  = measuring ? pen_touch_irq_ff : xpSync_ff[1];
      nxt_afe     = afe_for(measuring ? ch_ff : adcCtrl.channel, refCtrl, measuring);
      // New data wins over a read clear of the same result
      nxt_newData = newData_ff;
      if (rdStrobe) nxt_newData[rdAddr] = 1'b0;
      if (wrEn) nxt_newData[ch_ff] = 1'b1;                     // [R18]
      nxt_ready   = (nxt_newData == '0);
   end

   // ======
   // State registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= ST_IDLE;
         ch_ff      <= CH_Y;
         dly_ff     <= STAB_DELAY_RST;
         tick_ff    <= '0;
         avgPass_ff <= 1'b0;
         accum_ff   <= '0;
         newData_ff <= '0;
         pen_touch_irq_ff  <= 1'b1;
         ready_ff   <= 1'b1;
         sw_ff      <= '0;
         afe_ff     <= '0;
         busy_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         ch_ff      <= nxt_ch;
         dly_ff     <= nxt_dly;
         tick_ff    <= nxt_tick;
         avgPass_ff <= nxt_avgPass;
         accum_ff   <= nxt_accum;
         newData_ff <= nxt_newData;
         pen_touch_irq_ff  <= nxt_pen_touch_irq;
         ready_ff   <= nxt_ready;
         sw_ff      <= nxt_sw;
         afe_ff     <= nxt_afe;
         busy_ff    <= nxt_busy;
      end
   end

   // Outputs
   assign panelSw             = sw_ff;
   assign afeSel              = afe_ff;
   assign dacCode             = sarDac;
   assign sampling            = sarSampling;
   assign pen_touch_irq_n     = pen_touch_irq_ff;
   assign result_ready_flag_n = ready_ff;
   assign busy                = busy_ff;
endmodule : touch_panel_adc_sequencer

// >>> tb/touch_seq_monitor.sv
// Concurrent checks on the touch panel converter sequencer ports.
// Bound to the sequencer top; one clock, async low reset.
`timescale 1ns/1ns
module touch_seq_monitor (
   // Clock and reset
   input wire logic                     clk_sys,
   input wire logic                     rst_n,
   // Inputs watched
   input wire touch_adc_pkg::adc_ctrl_t adcCtrl,
   input wire touch_adc_pkg::ref_ctrl_t refCtrl,
   input wire logic                     hostCmdValid,
   input wire touch_adc_pkg::host_cmd_t hostCmd,
   // Outputs watched
   input wire touch_adc_pkg::panel_sw_t panelSw,
   input wire touch_adc_pkg::afe_sel_t  afeSel,
   input wire logic                     sampling,
   input wire logic                     busy
);
   import touch_adc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ======
   // Switches and front end while sampling
   chk_y_drive: assert property (sampling && afeSel.muxSel == CH_Y |->
      panelSw.ypToVdd && panelSw.ynToGnd && !panelSw.xpToVdd) else $error("Y drive");
   chk_x_drive: assert property (sampling && afeSel.muxSel == CH_X |->
      panelSw.xpToVdd && panelSw.xnToGnd && !panelSw.ypToVdd) else $error("X drive");
   chk_pen_cut: assert property (sampling |-> !panelSw.xpToPenIrq)
      else $error("Pen path on");
   chk_diff_panel: assert property (sampling && afeSel.muxSel < CH_BAT |->
      afeSel.diffMode) else $error("Not differential");
   chk_ref_single: assert property (sampling && afeSel.muxSel >= CH_BAT |->
      !afeSel.diffMode && afeSel.useIntRef == refCtrl.intRefOn) else $error("Reference");
   // ======
   // Timing and commands
   chk_sample_len: assert property ($rose(sampling) |-> ##35 sampling ##1 !sampling)
      else $error("Sampling length");
   chk_conv_start: assert property (hostCmdValid && hostCmd == HCMD_CONVERT && !busy &&
      adcCtrl.mode == MODE_HOST_CTRL |-> ##[1:2] busy) else $error("Convert lost");
   chk_scan_refused: assert property (hostCmdValid && hostCmd == HCMD_SCAN && !busy &&
      adcCtrl.mode == MODE_HOST_CTRL |=> !busy ##1 !busy) else $error("Scan taken");
   chk_host_idle: assert property ((adcCtrl.mode == MODE_HOST_CTRL && !busy &&
      !hostCmdValid) [*3] |=> !busy) else $error("Idle start");
endmodule : touch_seq_monitor

bind touch_panel_adc_sequencer touch_seq_monitor touch_seq_monitor_inst (.clk_sys, .rst_n,
   .adcCtrl, .refCtrl, .hostCmdValid, .hostCmd, .panelSw, .afeSel, .sampling, .busy);

// >>> tb/touch_panel_model.sv
// Touch panel and analog inputs seen from the sequencer pins.
// Assumes one fixed level per channel and a pull-up on x-positive.
`timescale 1ns/1ns
module touch_panel_model (
   // From the sequencer, plus touched from the bench
   input  wire touch_adc_pkg::panel_sw_t panelSw,
   input  wire touch_adc_pkg::afe_sel_t  afeSel,
   input  wire logic [11:0]              dacCode,
   input  wire logic                     touched,
   // To the sequencer
   output logic                          xpSense,
   output logic                          cmpPin
);
   import touch_adc_pkg::*;
   // ======
   // High while the level is at or above the trial
   assign cmpPin = dacCode <= {afeSel.muxSel, 9'h0a5};
   // Pen closes x-positive onto grounded y-negative, else pulled up
   assign xpSense = !(touched && panelSw.ynToGnd);
endmodule : touch_panel_model

// >>> tb/touch_panel_adc_sequencer_tb.sv
// Self-checking bench for the touch panel converter sequencer.
// Assumes the panel model and the bound checker.
`timescale 1ns/1ns
module touch_panel_adc_sequencer_tb;
   import touch_adc_pkg::*;
   typedef struct packed {channel_t ch; resolution_t res; clk_div_t div; logic [3:0] bits;} row_t;
   logic clk_sys, rst_n, hostCmdValid, rdStrobe, xpSense, cmpPin, extRef, touched, sampling;
   logic pen_touch_irq_n, result_ready_flag_n, busy;
   logic [2:0] rdAddr, sg;
   logic [7:0] stabDelay;
   logic [11:0] dacCode;
   logic [15:0] rdData;
   adc_ctrl_t adcCtrl;
   ref_ctrl_t refCtrl;
   host_cmd_t hostCmd;
   panel_sw_t panelSw;
   afe_sel_t afeSel;
   int errors, comparisons, n;
   // Channel, resolution, divider, bits
   row_t rows[4] = '{'{CH_Y, RES_12, DIV_4, 4'hc}, '{CH_X, RES_12, DIV_8, 4'hc},
      '{CH_BAT, RES_10, DIV_2, 4'ha}, '{CH_AUX, RES_8, DIV_1, 4'h8}};
   assign sg = {pen_touch_irq_n, result_ready_flag_n, busy};
   touch_panel_adc_sequencer touch_panel_adc_sequencer_inst (.clk_sys, .rst_n, .adcCtrl,
      .refCtrl, .stabDelay, .hostCmdValid, .hostCmd, .rdStrobe, .rdAddr, .rdData, .xpSense,
      .cmpPin, .ext_reference_input(extRef), .panelSw, .afeSel, .dacCode, .sampling,
      .pen_touch_irq_n, .result_ready_flag_n, .busy);
   touch_panel_model touch_panel_model_inst (.panelSw, .afeSel, .dacCode, .touched,
      .xpSense, .cmpPin);
   // ======
   // Clock and helpers
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic logic [11:0] lvl(input logic [2:0] c);
      return {c, 9'h0a5};
   endfunction : lvl
   task automatic check(input logic ok);
      comparisons++;
      if (ok !== 1'b1) begin
         errors++;
         $display("BAD %0t mismatch", $time);
      end
   endtask : check
   task automatic complete_run;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run
   // Bounded wait for sg[s] to reach v; sg is {pen, ready, busy}
   task automatic waitOn(input int s, input logic v, input int lim);
      n = 0;
      while (sg[s] !== v) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > lim) begin
            errors++;
            $display("BAD %0t timeout", $time);
            complete_run();
         end
      end
   endtask : waitOn
   task automatic cmd(input host_cmd_t c);
      @(posedge clk_sys);
      hostCmdValid <= 1'b1;
      hostCmd <= c;
      @(posedge clk_sys);
      hostCmdValid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : cmd
   task automatic readChk(input logic [2:0] a, input logic [11:0] e);
      waitOn(1, 1'b0, 8);
      @(posedge clk_sys);
      rdAddr <= a;
      rdStrobe <= 1'b1;
      @(posedge clk_sys);
      rdStrobe <= 1'b0;
      #1;
      check(rdData === {4'h0, e});
   endtask : readChk
   // ======
   // Main sequence
   initial begin
      errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      hostCmdValid = 1'b0;
      hostCmd = HCMD_NONE;
      rdStrobe = 1'b0;
      rdAddr = 3'h0;
      extRef = 1'b0;
      touched = 1'b0;
      stabDelay = 8'h04;
      refCtrl = 3'h6;
      adcCtrl = {MODE_HOST_CTRL, CH_Y, SCAN_ONE, 1'b0, RES_12, DIV_4};
      repeat (10) @(posedge clk_sys);
      check(sg === 3'h6);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk_sys);
         adcCtrl.channel <= rows[i].ch;
         adcCtrl.res <= rows[i].res;
         adcCtrl.div <= rows[i].div;
         refCtrl.intRefOn <= i[0];
         cmd(HCMD_CONVERT);
         waitOn(0, 1'b0, 30000);
         check(n + 5 >= 36 + rows[i].bits * (12 << rows[i].div));
         readChk(rows[i].ch, lvl(rows[i].ch) >> (12 - rows[i].bits));
         waitOn(1, 1'b1, 4);
      end
      // Drivers only, settle, then a separate conversion
      @(posedge clk_sys);
      adcCtrl.channel <= CH_Y;
      adcCtrl.res <= RES_12;
      adcCtrl.div <= DIV_4;
      cmd(HCMD_DRIVE);
      repeat (30) @(posedge clk_sys);
      check(panelSw.ypToVdd === 1'b1 && sampling === 1'b0);
      cmd(HCMD_CONVERT);
      waitOn(0, 1'b0, 30000);
      readChk(CH_Y, lvl(CH_Y));
      cmd(HCMD_SCAN);
      check(busy === 1'b0);
      // Pen answered by a host-started averaged pressure scan
      @(posedge clk_sys);
      adcCtrl.mode <= MODE_HOST_START;
      adcCtrl.scan <= SCAN_XYZ;
      adcCtrl.average <= 1'b1;
      touched <= 1'b1;
      waitOn(2, 1'b0, 6);
      cmd(HCMD_SCAN);
      waitOn(0, 1'b0, 30000);
      check(n + 5 >= 8 * (36 + 12 * 48) + 48);
      for (int c = 0; c < 4; c++) begin
         readChk(c[2:0], lvl(c[2:0]));
      end
      waitOn(1, 1'b1, 4);
      // Touch-started XY scan, pen released once it starts
      @(posedge clk_sys);
      touched <= 1'b0;
      waitOn(2, 1'b1, 6);
      @(posedge clk_sys);
      adcCtrl.mode <= MODE_TOUCH_AUTO;
      adcCtrl.scan <= SCAN_XY;
      touched <= 1'b1;
      waitOn(0, 1'b1, 200);
      @(posedge clk_sys);
      touched <= 1'b0;
      waitOn(0, 1'b0, 30000);
      complete_run();
   end
endmodule : touch_panel_adc_sequencer_tb
